// ---- verif/seq_assertions.sv ----
// Port checker for the status and error queue unit.
// Assumes the unit's top ports; bound below.
`timescale 1ns/10ps
`default_nettype none
`include "seq_defines.svh"
module seq_assertions
	import seq_pkg::*;
(
	input wire logic                   ref_clk,
	input wire logic                   reset_n,
	input wire seq_cmd_t               cmd,
	input wire logic [2:0]             errCount,
	input wire logic                   errQueueBit,
	input wire logic                   tempCond,
	input wire logic                   tempEvent,
	input wire logic                   tempEna,
	input wire logic                   tempPtr,
	input wire logic                   tempNtr,
	input wire logic [`SEQ_QUES_W-1:0] quesCond,
	input wire logic [`SEQ_QUES_W-1:0] quesEvent,
	input wire logic [`SEQ_QUES_W-1:0] quesEna,
	input wire logic [`SEQ_QUES_W-1:0] quesPtr,
	input wire logic [`SEQ_QUES_W-1:0] quesNtr,
	input wire logic                   quesSummary
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_depth; errCount <= 3'h4; endproperty
	a_depth: assert property (p_depth) else $error("count above depth");
	property p_qbit; errQueueBit == (errCount != 3'h0); endproperty
	a_qbit: assert property (p_qbit) else $error("queue bit wrong");
	property p_sum; 1'h1 |=> quesSummary == (|$past(quesEvent & quesEna)); endproperty
	a_sum: assert property (p_sum) else $error("summary wrong");
	property p_bit4; 1'h1 |=> quesCond[4] == $past(tempEvent & tempEna); endproperty
	a_bit4: assert property (p_bit4) else $error("bit four wrong");
	property p_evt; $rose(tempCond) && tempPtr |=> tempEvent; endproperty
	a_evt: assert property (p_evt) else $error("event not latched");
	property p_cls; cmd == SEQ_CMD_CLS |=> !tempEvent ##1 errCount == 3'h0; endproperty
	a_cls: assert property (p_cls) else $error("clear incomplete");
	property p_pre; cmd == SEQ_CMD_PRESET |=> quesEna == 16'h0000 && quesPtr == 16'hFFFF
		&& quesNtr == 16'h0000 && tempEna && tempPtr && tempNtr; endproperty
	a_pre: assert property (p_pre) else $error("preset values wrong");
	property p_rst; cmd == SEQ_CMD_RST |=> $stable(quesEna) && $stable(quesPtr)
		&& $stable(quesNtr) && $stable(tempEna); endproperty
	a_rst: assert property (p_rst) else $error("reset touched enables");
endmodule // seq_assertions
bind status_error_queue_unit seq_assertions u_chk (.ref_clk, .reset_n, .cmd, .errCount,
	.errQueueBit, .tempCond, .tempEvent, .tempEna, .tempPtr, .tempNtr, .quesCond,
	.quesEvent, .quesEna, .quesPtr, .quesNtr, .quesSummary);
`default_nettype wire

// ---- verif/seq_host.sv ----
// Host model: issues one-cycle command strobes.
// Assumes requests arrive only while busy is low.
`timescale 1ns/10ps
`default_nettype none
module seq_host
	import seq_pkg::*;
#(parameter int WaitCycles = 20) (
	input  wire logic     ref_clk,
	input  wire logic     go,
	input  wire seq_cmd_t req,
	output seq_cmd_t      cmd,
	output logic          busy
);
	initial begin
		cmd = SEQ_CMD_NONE;
		busy = 1'h0;
	end
	always @(posedge go) begin
		busy = 1'h1;
		@(negedge ref_clk) cmd = req;
		@(negedge ref_clk) cmd = SEQ_CMD_NONE;
		// Shortened; the unit does not enforce it
		if (req == SEQ_CMD_RST) repeat (WaitCycles) @(negedge ref_clk);
		busy = 1'h0;
	end
endmodule // seq_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the status and error queue unit.
// Assumes unit, host model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "seq_defines.svh"
module tb_top
	import seq_pkg::*;
;
	logic ref_clk = 1'h0, reset_n = 1'h0, overTempPin = 1'h0, errPush = 1'h0, errPop = 1'h0;
	logic tempEventRd = 1'h0, quesEventRd = 1'h0, go = 1'h0, busy;
	logic [5:0] wrStb = 6'h00;
	logic [15:0] errCode = 16'h0000, wrData = 16'h0000, headCode, quesEna, quesEvent, r;
	logic [7:0] errDesc = 8'h00, headDesc;
	logic [2:0] errCount;
	logic errQueueBit, tempEvent, tempEna, tempPtr, tempNtr, quesSummary, cmdIdle;
	seq_cmd_t cmd, req = SEQ_CMD_NONE;
	int badCount = 0, samplesChecked = 0;
	logic [18:0] notes[$];
	always #10 ref_clk = ~ref_clk;
	seq_host u_host (.ref_clk, .go, .req, .cmd, .busy);
	status_error_queue_unit u_dut (.ref_clk, .reset_n, .overTempPin, .errPush, .errCode,
		.errDesc, .errPop, .cmd, .tempEnaWr(wrStb[0]), .tempPtrWr(wrStb[1]),
		.tempNtrWr(wrStb[2]), .quesEnaWr(wrStb[3]), .quesPtrWr(wrStb[4]), .quesNtrWr(wrStb[5]),
		.wrData, .tempEventRd, .quesEventRd, .headCode, .headDesc, .errCount, .errQueueBit,
		.tempCond(), .tempEvent, .tempEna, .tempPtr, .tempNtr, .quesCond(), .quesEvent,
		.quesEna, .quesPtr(), .quesNtr(), .quesSummary, .cmdIdle);
	task automatic check(input string name, input logic [18:0] seen, exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic completeRun;
		$display("checks %0d mismatches %0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Three cycles per strobe so the lagging outputs settle
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge ref_clk) s = 1'h0;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic push(input logic [15:0] c);
		errCode = c;
		errDesc = c[7:0];
		pulse(errPush);
	endtask
	task automatic wr(input int i, input logic [15:0] d);
		wrData = d;
		wrStb[i] = 1'h1;
		@(negedge ref_clk) wrStb = 6'h00;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic issue(input seq_cmd_t c);
		int n;
		req = c;
		go = 1'h1;
		@(negedge ref_clk) go = 1'h0;
		for (n = 0; n < 100 && busy; n++) @(negedge ref_clk);
		if (busy) begin
			badCount++;
			completeRun;
		end
		repeat (2) @(negedge ref_clk);
	endtask
	// Pop results are compared against the oldest note
	always @(posedge ref_clk) begin
		if (errPop === 1'h1) begin
			if (notes.size() == 0) check("notes", 19'h00000, 19'h7FFFF);
			else check("head", {errCount, headCode}, notes.pop_front());
		end
	end
	initial begin
		logic [15:0] c[5];
		void'($urandom(9111));
		repeat (2) @(negedge ref_clk);
		reset_n = 1'h1;
		for (int i = 0; i < 5; i++) begin
			c[i] = 16'(($urandom % 32'h7FFE) + 1);
			push(c[i]);
		end
		notes.push_back({3'h4, c[0]});
		notes.push_back({3'h3, c[1]});
		notes.push_back({3'h2, c[2]});
		notes.push_back({3'h1, `SEQ_CODE_OVERFLOW});
		notes.push_back({3'h0, `SEQ_CODE_NONE});
		repeat (5) pulse(errPop);
		check("queueBit", errQueueBit, 19'h0);
		$display("test queue done");
		overTempPin = 1'h1;
		repeat (6) @(negedge ref_clk);
		check("tempRise", tempEvent, 19'h1);
		wr(3, 16'h0010);
		check("summary", quesSummary, 19'h1);
		pulse(tempEventRd);
		check("tempRead", tempEvent, 19'h0);
		overTempPin = 1'h0;
		repeat (6) @(negedge ref_clk);
		check("tempFall", tempEvent, 19'h1);
		push(16'hFF9A);
		issue(SEQ_CMD_PRESET);
		check("presetKeep", {tempEvent, errCount}, 19'h9);
		pulse(quesEventRd);
		check("quesRead", quesEvent, 19'h0);
		r = 16'($urandom);
		wr(3, r);
		issue(SEQ_CMD_RST);
		issue(SEQ_CMD_READ);
		check("rstKeep", quesEna, r);
		check("idle", {cmdIdle, errCount}, 19'h9);
		issue(SEQ_CMD_CLS);
		check("clear", {tempEvent, errCount}, 19'h0);
		$display("test status done");
		push(16'h1234);
		push(16'h5678);
		check("headDesc", headDesc, 19'h34);
		notes.push_back({3'h2, 16'h1234});
		notes.push_back({3'h2, 16'h5678});
		notes.push_back({3'h1, 16'h9ABC});
		errCode = 16'h9ABC;
		errPush = 1'h1;
		errPop = 1'h1;
		@(negedge ref_clk) errPush = 1'h0;
		errPop = 1'h0;
		repeat (2) @(negedge ref_clk);
		repeat (2) pulse(errPop);
		check("notesLeft", 19'(notes.size()), 19'h0);
		$display("test pushpop done");
		completeRun;
	end
endmodule // tb_top
`default_nettype wire

// ---- verilog/seq_defines.svh ----
// Constants for the status and error queue unit.
// Assumes inclusion by bare name from the design file.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
`define SEQ_CODE_W 16
`define SEQ_CODE_NONE 16'h0000
`define SEQ_CODE_OVERFLOW 16'hFEA2
`define SEQ_QUEUE_DEPTH 4
`define SEQ_DESC_MAX 255
`define SEQ_LINE_MAX 80
`define SEQ_TEMP_W 1
`define SEQ_QUES_TEMP_BIT 4
`define SEQ_QUES_W 16
`define SEQ_MAND_ENA_PRESET 16'h0000
`define SEQ_MAND_PTR_PRESET 16'hFFFF
`define SEQ_MAND_NTR_PRESET 16'h0000
`define SEQ_DEV_ENA_PRESET 1'h1
`define SEQ_DEV_PTR_PRESET 1'h1
`define SEQ_DEV_NTR_PRESET 1'h1
`define SEQ_RESET_WAIT_MS 2000
`endif

// ---- verilog/seq_pkg.sv ----
// Types for the status and error queue unit.
// Assumes the defines header is compiled alongside.
package seq_pkg;
	typedef enum logic [4:0] {
		SEQ_CMD_NONE   = 5'h01,
		SEQ_CMD_CLS    = 5'h02,
		SEQ_CMD_PRESET = 5'h04,
		SEQ_CMD_RST    = 5'h08,
		SEQ_CMD_READ   = 5'h10
	} seq_cmd_t;
endpackage

// ---- verilog/status_error_queue_unit.sv ----
// Status reporting: temperature sub-register, four-entry error queue, clears.
// Assumes a command decoder on ref_clk issues one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
`include "seq_defines.svh"

module status_error_queue_unit
	import seq_pkg::*;
#(
	parameter int QueueDepth = `SEQ_QUEUE_DEPTH,
	parameter int CodeWidth  = `SEQ_CODE_W,
	parameter int DescWidth  = 8
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   overTempPin,
	input  wire logic                   errPush,
	input  wire logic [CodeWidth-1:0]   errCode,
	input  wire logic [DescWidth-1:0]   errDesc,
	input  wire logic                   errPop,
	input  wire seq_cmd_t               cmd,
	input  wire logic                   tempEnaWr,
	input  wire logic                   tempPtrWr,
	input  wire logic                   tempNtrWr,
	input  wire logic                   quesEnaWr,
	input  wire logic                   quesPtrWr,
	input  wire logic                   quesNtrWr,
	input  wire logic [`SEQ_QUES_W-1:0] wrData,
	input  wire logic                   tempEventRd,
	input  wire logic                   quesEventRd,
	output logic [CodeWidth-1:0]        headCode,
	output logic [DescWidth-1:0]        headDesc,
	output logic [2:0]                  errCount,
	output logic                        errQueueBit,
	output logic                        tempCond,
	output logic                        tempEvent,
	output logic                        tempEna,
	output logic                        tempPtr,
	output logic                        tempNtr,
	output logic [`SEQ_QUES_W-1:0]      quesCond,
	output logic [`SEQ_QUES_W-1:0]      quesEvent,
	output logic [`SEQ_QUES_W-1:0]      quesEna,
	output logic [`SEQ_QUES_W-1:0]      quesPtr,
	output logic [`SEQ_QUES_W-1:0]      quesNtr,
	output logic                        quesSummary,
	output logic                        cmdIdle
);

	// Pointer and count widths are sized for four entries only
	if (QueueDepth != `SEQ_QUEUE_DEPTH || CodeWidth != `SEQ_CODE_W || DescWidth < 1) begin : g_badParam
		$error("Unsupported parameter set");
	end

	// Transition filter shared by both levels of the structure
	function automatic logic [`SEQ_QUES_W-1:0] edgeHit(
		input logic [`SEQ_QUES_W-1:0] prev,
		input logic [`SEQ_QUES_W-1:0] now,
		input logic [`SEQ_QUES_W-1:0] ptr,
		input logic [`SEQ_QUES_W-1:0] ntr);
		edgeHit = (~prev & now & ptr) | (prev & ~now & ntr);
	endfunction

	// Pin synchroniser; first stage read only by the second
	logic otSync1_q;
	logic otSync2_q;
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			otSync1_q <= 1'b0;
			otSync2_q <= 1'b0;
		end else begin
			otSync1_q <= overTempPin;
			otSync2_q <= otSync1_q;
		end
	end

	// Queue storage, oldest at rdPtr
	logic [CodeWidth-1:0] codeMem [QueueDepth];
	logic [DescWidth-1:0] descMem [QueueDepth];
	logic [1:0]           rdPtr_q;
	logic [2:0]           cnt_q;
	logic                 full;
	logic                 empty;
	logic                 doPop;
	logic                 doClear;
	logic [1:0]           wrIdx;
	logic [1:0]           lastIdx;

	assign full    = (cnt_q == 3'(QueueDepth));
	assign empty   = (cnt_q == 3'h0);
	assign doClear = (cmd == SEQ_CMD_CLS);
	assign doPop   = errPop && !empty;
	// Slot after the tail; with a pop the freed head slot wraps in when full
	assign wrIdx   = rdPtr_q + cnt_q[1:0];
	assign lastIdx = rdPtr_q + 2'h3;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdPtr_q <= 2'h0;
			cnt_q   <= 3'h0;
		end else if (doClear) begin
			rdPtr_q <= 2'h0;
			cnt_q   <= 3'h0;
		end else begin
			if (doPop)
				rdPtr_q <= rdPtr_q + 2'h1;
			if (errPush && (!full || doPop) && !doPop)
				cnt_q <= cnt_q + 3'h1;
			else if (doPop && !(errPush))
				cnt_q <= cnt_q - 3'h1;
		end
	end

	// Descriptions are an index into a fixed text table limited to 255 chars
	always_ff @(posedge ref_clk) begin
		if (!doClear && errPush) begin
			if (full && !doPop) begin
				codeMem[lastIdx] <= `SEQ_CODE_OVERFLOW;
				descMem[lastIdx] <= '1;
			end else begin
				codeMem[wrIdx] <= errCode;
				descMem[wrIdx] <= errDesc;
			end
		end
	end

	// Registered head and count views
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			headCode    <= `SEQ_CODE_NONE;
			headDesc    <= '0;
			errCount    <= 3'h0;
			errQueueBit <= 1'b0;
		end else begin
			errCount    <= cnt_q;
			errQueueBit <= !empty;
			if (empty) begin
				headCode <= `SEQ_CODE_NONE;
				headDesc <= '0;
			end else begin
				headCode <= codeMem[rdPtr_q];
				headDesc <= descMem[rdPtr_q];
			end
		end
	end

	// Temperature sub-register; device reset deliberately absent below
	logic                   tempHit;
	logic                   tempSum;
	logic [`SEQ_QUES_W-1:0] tempHitVec;
	assign tempHitVec = edgeHit(`SEQ_QUES_W'(tempCond), `SEQ_QUES_W'(otSync2_q),
		`SEQ_QUES_W'(tempPtr), `SEQ_QUES_W'(tempNtr));
	assign tempHit = tempHitVec[0];
	assign tempSum = tempEvent & tempEna;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tempCond  <= 1'b0;
			tempEvent <= 1'b0;
		end else begin
			tempCond <= otSync2_q;
			if (tempHit)
				tempEvent <= 1'b1;
			else if (doClear || tempEventRd)
				tempEvent <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tempEna <= `SEQ_DEV_ENA_PRESET;
			tempPtr <= `SEQ_DEV_PTR_PRESET;
			tempNtr <= `SEQ_DEV_NTR_PRESET;
		end else if (cmd == SEQ_CMD_PRESET) begin
			tempEna <= `SEQ_DEV_ENA_PRESET;
			tempPtr <= `SEQ_DEV_PTR_PRESET;
			tempNtr <= `SEQ_DEV_NTR_PRESET;
		end else begin
			if (tempEnaWr)
				tempEna <= wrData[0];
			if (tempPtrWr)
				tempPtr <= wrData[0];
			if (tempNtrWr)
				tempNtr <= wrData[0];
		end
	end

	// Questionable register: temperature summary enters bit four
	logic [`SEQ_QUES_W-1:0] quesNow;
	logic [`SEQ_QUES_W-1:0] quesHit;
	always_comb begin
		quesNow = '0;
		quesNow[`SEQ_QUES_TEMP_BIT] = tempSum;
	end
	assign quesHit = edgeHit(quesCond, quesNow, quesPtr, quesNtr);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			quesCond    <= '0;
			quesEvent   <= '0;
			quesSummary <= 1'b0;
		end else begin
			quesCond    <= quesNow;
			quesSummary <= |(quesEvent & quesEna);
			if (doClear || quesEventRd)
				quesEvent <= quesHit;
			else
				quesEvent <= quesEvent | quesHit;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			quesEna <= `SEQ_MAND_ENA_PRESET;
			quesPtr <= `SEQ_MAND_PTR_PRESET;
			quesNtr <= `SEQ_MAND_NTR_PRESET;
		end else if (cmd == SEQ_CMD_PRESET) begin
			quesEna <= `SEQ_MAND_ENA_PRESET;
			quesPtr <= `SEQ_MAND_PTR_PRESET;
			quesNtr <= `SEQ_MAND_NTR_PRESET;
		end else begin
			if (quesEnaWr)
				quesEna <= wrData;
			if (quesPtrWr)
				quesPtr <= wrData;
			if (quesNtrWr)
				quesNtr <= wrData;
		end
	end

	// Device reset only idles the command path; status is kept
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			cmdIdle <= 1'b1;
		else if (cmd == SEQ_CMD_RST)
			cmdIdle <= 1'b1;
		else
			cmdIdle <= (cmd == SEQ_CMD_NONE);
	end

	// Help text is produced by firmware, not this block

endmodule // status_error_queue_unit
`default_nettype wire
